// [pxc_ext_ctrl.sv]
// Extended control register bank behind the serial management port
`timescale 1ns/100ps

// Contract
// - Polarity inhibit set stops automatic polarity correction
// - SQE and squelch inhibits disable those functions
// - Link loss inhibit forces link pass
// - Speed source picks control bit or pin
// - Bank field 01 extends map; 1x equals 00
// - Tri-state bit floats line transmit outputs
// - Auto power-down bit resets one, enables power-down
module pxc_ext_ctrl #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    // Management pins
    input  wire logic        mdc_i,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe_n_o,
    // Straps and pins
    input  wire logic        strap_node_mode_i,
    input  wire logic        strap_speed_src_i,
    input  wire logic        speed_pin_i,
    // Core status and control
    input  wire logic        basic_speed_sel_i,
    input  wire logic        remote_fault_i,
    input  wire logic        link_pass_raw_i,
    // Controls to the line logic
    output logic             pol_correct_dis_o,
    output logic             sqe_test_dis_o,
    output logic             squelch_dis_o,
    output logic             link_pass_o,
    output logic             speed_100_o,
    output logic             repeater_mode_o,
    output logic [1:0]       bank_sel_o,
    output logic             crossover_auto_enable_o,
    output logic             crossover_manual_select_o,
    output logic             line_output_tristate_o,
    output logic             auto_powerdown_en_o,
    output logic [15:0]      out_led_ctrl_o
);
    // Two-stage synchronisers for every pin; mdc gets a third for edges
    logic [1:0] mdc_s_r, mdi_s_r, node_s_r, spds_s_r, spdp_s_r;
    logic       mdc_d_r;
    always_ff @(posedge clk_sys_i) begin
        mdc_s_r  <= {mdc_s_r[0], mdc_i};
        mdi_s_r  <= {mdi_s_r[0], mdio_i};
        node_s_r <= {node_s_r[0], strap_node_mode_i};
        spds_s_r <= {spds_s_r[0], strap_speed_src_i};
        spdp_s_r <= {spdp_s_r[0], speed_pin_i};
        mdc_d_r  <= mdc_s_r[1];
    end

    wire logic mdc_rise = mdc_s_r[1] & ~mdc_d_r;
    wire logic mdi      = mdi_s_r[1];

    // Register state
    logic [3:0]  ops_r, ops_nxt;
    logic [15:0] ext_r, ext_nxt;
    logic [15:0] led_r, led_nxt;
    logic        link_r, link_nxt;
    logic        spd_r, spd_nxt;

    // Frame engine state
    pxc_pkg::pxc_mgmt_state_e st_r, st_nxt;
    logic [5:0]  pre_r, pre_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic        rd_r, rd_nxt;
    logic [4:0]  addr_r, addr_nxt;
    logic        oe_n_r, oe_n_nxt;
    logic        mdo_r, mdo_nxt;
    logic        wr_stb_r, wr_stb_nxt;
    logic [15:0] wr_data_r, wr_data_nxt;
    logic [15:0] rd_data;
    logic [15:0] ext_view;
    logic        ext_bank;

    // Live view of extended_control_a; read-only bits come from remote_fault_i and zero
    always_comb begin
        ext_view = ext_r;
        ext_view[pxc_pkg::EXT_RFAULT]  = remote_fault_i;
        ext_view[pxc_pkg::EXT_RSVD_RO] = 1'b0;
    end

    assign ext_bank = (ext_r[pxc_pkg::EXT_BANK_HI:pxc_pkg::EXT_BANK_LO]
                       == pxc_pkg::BANK_EXT);

    // Read mux; the extended set is not built here and reads zero
    always_comb begin
        rd_data = 16'h0000;
        if (addr_r == pxc_pkg::OFF_TBT_OPS) begin
            rd_data = {12'h000, ops_r};
        end else if (addr_r == pxc_pkg::OFF_EXT_A) begin
            rd_data = ext_view;
        end else if (addr_r == pxc_pkg::OFF_OUT_LED && !ext_bank) begin
            rd_data = led_r;
        end
    end

    // Frame engine: sampled on each rising management clock edge
    always_comb begin
        st_nxt      = st_r;
        pre_nxt     = pre_r;
        cnt_nxt     = cnt_r;
        sh_nxt      = sh_r;
        rd_nxt      = rd_r;
        addr_nxt    = addr_r;
        oe_n_nxt    = oe_n_r;
        mdo_nxt     = mdo_r;
        wr_stb_nxt  = 1'b0;
        wr_data_nxt = wr_data_r;
        if (mdc_rise) begin
            case (st_r)
                pxc_pkg::ST_PRE: begin
                    if (mdi) begin
                        if (pre_r != pxc_pkg::PRE_BITS) begin
                            pre_nxt = pre_r + 6'h01;
                        end
                    end else if (pre_r == pxc_pkg::PRE_BITS) begin
                        st_nxt  = pxc_pkg::ST_HDR;
                        cnt_nxt = 5'h00;
                    end else begin
                        pre_nxt = 6'h00;
                    end
                end
                pxc_pkg::ST_HDR: begin
                    sh_nxt  = {sh_r[14:0], mdi};
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == pxc_pkg::HDR_LAST) begin
                        pre_nxt  = 6'h00;
                        cnt_nxt  = 5'h00;
                        rd_nxt   = (sh_nxt[11:10] == pxc_pkg::OP_RD);
                        addr_nxt = sh_nxt[4:0];
                        // Bad start, bad opcode or other address: drop it
                        if (sh_nxt[12] && sh_nxt[9:5] == PHY_ADDR &&
                            (sh_nxt[11:10] == pxc_pkg::OP_RD ||
                             sh_nxt[11:10] == pxc_pkg::OP_WR)) begin
                            st_nxt = pxc_pkg::ST_TA;
                        end else begin
                            st_nxt = pxc_pkg::ST_PRE;
                        end
                    end
                end
                pxc_pkg::ST_TA: begin
                    if (cnt_r == 5'h00) begin
                        cnt_nxt = 5'h01;
                        // Drive the turnaround zero only on reads
                        if (rd_r) begin
                            oe_n_nxt = 1'b0;
                            mdo_nxt  = 1'b0;
                        end
                    end else begin
                        cnt_nxt = 5'h00;
                        if (rd_r) begin
                            sh_nxt  = rd_data;
                            mdo_nxt = rd_data[15];
                            st_nxt  = pxc_pkg::ST_RD;
                        end else begin
                            st_nxt  = pxc_pkg::ST_WR;
                        end
                    end
                end
                pxc_pkg::ST_RD: begin
                    cnt_nxt = cnt_r + 5'h01;
                    sh_nxt  = {sh_r[14:0], 1'b0};
                    mdo_nxt = sh_r[14];
                    if (cnt_r == pxc_pkg::DATA_LAST) begin
                        oe_n_nxt = 1'b1;
                        mdo_nxt  = 1'b0;
                        st_nxt   = pxc_pkg::ST_PRE;
                    end
                end
                pxc_pkg::ST_WR: begin
                    cnt_nxt = cnt_r + 5'h01;
                    sh_nxt  = {sh_r[14:0], mdi};
                    if (cnt_r == pxc_pkg::DATA_LAST) begin
                        wr_stb_nxt  = 1'b1;
                        wr_data_nxt = sh_nxt;
                        st_nxt      = pxc_pkg::ST_PRE;
                    end
                end
                default: begin
                    st_nxt = pxc_pkg::ST_PRE;
                end
            endcase
        end
    end

    // Frame engine registers; the pin is released in reset
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_r      <= pxc_pkg::ST_PRE;
            pre_r     <= 6'h00;
            cnt_r     <= 5'h00;
            sh_r      <= 16'h0000;
            rd_r      <= 1'b0;
            addr_r    <= 5'h00;
            oe_n_r    <= 1'b1;
            mdo_r     <= 1'b0;
            wr_stb_r  <= 1'b0;
            wr_data_r <= 16'h0000;
        end else begin
            st_r      <= st_nxt;
            pre_r     <= pre_nxt;
            cnt_r     <= cnt_nxt;
            sh_r      <= sh_nxt;
            rd_r      <= rd_nxt;
            addr_r    <= addr_nxt;
            oe_n_r    <= oe_n_nxt;
            mdo_r     <= mdo_nxt;
            wr_stb_r  <= wr_stb_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

    // Register writes and derived controls
    always_comb begin
        ops_nxt = ops_r;
        ext_nxt = ext_r;
        led_nxt = led_r;
        if (wr_stb_r) begin
            if (addr_r == pxc_pkg::OFF_TBT_OPS) begin
                // low nibble holds the four inhibits
                ops_nxt = wr_data_r[3:0];
            end else if (addr_r == pxc_pkg::OFF_EXT_A) begin
                // reserved bits stored, read-only bits cleared
                ext_nxt = wr_data_r & pxc_pkg::EXT_A_WMASK;
            end else if (addr_r == pxc_pkg::OFF_OUT_LED && !ext_bank) begin
                // codes 00 and 1x reach this register
                led_nxt = wr_data_r;
            end
        end
        link_nxt = link_pass_raw_i | ops_r[pxc_pkg::TBT_LINK_INH];
        // speed from pin or from the basic control bit
        spd_nxt  = ext_r[pxc_pkg::EXT_SPD_SRC] ? spdp_s_r[1]
                                               : basic_speed_sel_i;
    end

    // Register state; straps are caught while reset is held
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ops_r  <= pxc_pkg::TBT_OPS_RST;
            ext_r  <= pxc_pkg::EXT_A_RST |
                      {node_s_r[1], spds_s_r[1], 14'h0000};
            led_r  <= pxc_pkg::OUT_LED_RST;
            link_r <= 1'b0;
            spd_r  <= 1'b0;
        end else begin
            ops_r  <= ops_nxt;
            ext_r  <= ext_nxt;
            led_r  <= led_nxt;
            link_r <= link_nxt;
            spd_r  <= spd_nxt;
        end
    end

    // Outputs straight from flops
    assign mdio_o                    = mdo_r;
    assign mdio_oe_n_o               = oe_n_r;
    // inhibit controls to the 10Base-T logic
    assign pol_correct_dis_o         = ops_r[pxc_pkg::TBT_POL_INH];
    assign sqe_test_dis_o            = ops_r[pxc_pkg::TBT_SQE_INH];
    assign squelch_dis_o             = ops_r[pxc_pkg::TBT_SQL_INH];
    assign link_pass_o               = link_r;
    assign speed_100_o               = spd_r;
    assign repeater_mode_o           = ext_r[pxc_pkg::EXT_NODE];
    assign bank_sel_o = ext_r[pxc_pkg::EXT_BANK_HI:pxc_pkg::EXT_BANK_LO];
    assign crossover_auto_enable_o   = ext_r[pxc_pkg::EXT_XO_AUTO];
    assign crossover_manual_select_o = ext_r[pxc_pkg::EXT_XO_MAN];
    // tri-state control to the line driver
    assign line_output_tristate_o    = ext_r[pxc_pkg::EXT_TRI];
    assign auto_powerdown_en_o       = ext_r[pxc_pkg::EXT_APD];
    assign out_led_ctrl_o            = led_r;

    // Checks
    property p_pol_wr;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_stb_r && addr_r == pxc_pkg::OFF_TBT_OPS
        |=> pol_correct_dis_o == $past(wr_data_r[3]);
    endproperty
    a_pol_wr: assert property (p_pol_wr) else $error("pol inhibit");

    property p_sqe_sql;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_stb_r && addr_r == pxc_pkg::OFF_TBT_OPS
        |=> sqe_test_dis_o == $past(wr_data_r[2]) &&
            squelch_dis_o == $past(wr_data_r[0]);
    endproperty
    a_sqe_sql: assert property (p_sqe_sql) else $error("sqe/squelch");

    property p_link_inh;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        ops_r[pxc_pkg::TBT_LINK_INH] |=> link_pass_o;
    endproperty
    a_link_inh: assert property (p_link_inh) else $error("link pass");

    property p_spd_pin;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        ext_r[pxc_pkg::EXT_SPD_SRC] |=> speed_100_o == $past(spdp_s_r[1]);
    endproperty
    a_spd_pin: assert property (p_spd_pin) else $error("speed pin");

    property p_spd_bit;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !ext_r[pxc_pkg::EXT_SPD_SRC]
        |=> speed_100_o == $past(basic_speed_sel_i);
    endproperty
    a_spd_bit: assert property (p_spd_bit) else $error("speed bit");

    property p_bank_ext;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_stb_r && addr_r == pxc_pkg::OFF_OUT_LED && ext_bank
        |=> $stable(out_led_ctrl_o);
    endproperty
    a_bank_ext: assert property (p_bank_ext) else $error("bank 01");

    property p_bank_base;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_stb_r && addr_r == pxc_pkg::OFF_OUT_LED && !ext_bank
        |=> out_led_ctrl_o == $past(wr_data_r);
    endproperty
    a_bank_base: assert property (p_bank_base) else $error("bank 0");

    property p_tri;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_stb_r && addr_r == pxc_pkg::OFF_EXT_A
        |=> line_output_tristate_o == $past(wr_data_r[7]);
    endproperty
    a_tri: assert property (p_tri) else $error("tri-state");

    property p_apd_rst;
        @(posedge clk_sys_i) $fell(sys_rst_i) |-> auto_powerdown_en_o;
    endproperty
    a_apd_rst: assert property (p_apd_rst) else $error("apd reset");

    property p_rsvd;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_stb_r && addr_r == pxc_pkg::OFF_EXT_A
        |=> ext_r[6:1] == $past(wr_data_r[6:1]) &&
            auto_powerdown_en_o == $past(wr_data_r[0]);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved");

    property p_rd_frame;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        st_r == pxc_pkg::ST_RD;
    endproperty
    c_rd_frame: cover property (p_rd_frame);

    property p_wr_frame;
        @(posedge clk_sys_i) disable iff (sys_rst_i) wr_stb_r;
    endproperty
    c_wr_frame: cover property (p_wr_frame);

    property p_bank_sel;
        @(posedge clk_sys_i) disable iff (sys_rst_i) ext_bank;
    endproperty
    c_bank_sel: cover property (p_bank_sel);
endmodule

// [pxc_pkg.sv]
// Package with map, field positions and reset values of the extended control bank
package pxc_pkg;
    // Register offsets on the management bus
    localparam logic [4:0] OFF_TBT_OPS  = 5'h12;
    localparam logic [4:0] OFF_EXT_A    = 5'h13;
    localparam logic [4:0] OFF_OUT_LED  = 5'h14;
    // Fields of ten_base_t_operations
    localparam int TBT_POL_INH  = 3;
    localparam int TBT_SQE_INH  = 2;
    localparam int TBT_LINK_INH = 1;
    localparam int TBT_SQL_INH  = 0;
    // Fields of extended_control_a
    localparam int EXT_NODE     = 15;
    localparam int EXT_SPD_SRC  = 14;
    localparam int EXT_RFAULT   = 13;
    localparam int EXT_BANK_HI  = 12;
    localparam int EXT_BANK_LO  = 11;
    localparam int EXT_RSVD_RO  = 10;
    localparam int EXT_XO_AUTO  = 9;
    localparam int EXT_XO_MAN   = 8;
    localparam int EXT_TRI      = 7;
    localparam int EXT_APD      = 0;
    // Reset values and write mask
    localparam logic [3:0]  TBT_OPS_RST = 4'h0;
    localparam logic [15:0] EXT_A_RST   = 16'h0201;
    localparam logic [15:0] OUT_LED_RST = 16'h3FE9;
    localparam logic [15:0] EXT_A_WMASK = 16'hDBFF;
    // Bank code that maps the extended set from 0x14 upward
    localparam logic [1:0]  BANK_EXT    = 2'h1;
    // Management frame figures
    localparam logic [5:0]  PRE_BITS    = 6'h20;
    localparam logic [4:0]  HDR_LAST    = 5'h0C;
    localparam logic [4:0]  DATA_LAST   = 5'h0F;
    localparam logic [1:0]  OP_RD       = 2'h2;
    localparam logic [1:0]  OP_WR       = 2'h1;
    // Management frame states
    typedef enum logic [2:0] {
        ST_PRE, ST_HDR, ST_TA, ST_RD, ST_WR
    } pxc_mgmt_state_e;
endpackage

// [pxc_sta_model.sv]
// Station management model that sends MDIO frames to the bank
`timescale 1ns/100ps
module pxc_sta_model (
    // Bench clock
    input  wire logic clk_sys_i,
    // Management pins
    output logic      mdc_o,
    output logic      mdio_d_o,
    output logic      mdio_en_o,
    input  wire logic mdio_i
);
    // Idle with MDC low and the line released
    initial begin
        mdc_o = 1'b0;
        mdio_d_o = 1'b1;
        mdio_en_o = 1'b0;
    end

    // One MDC period of 8 clocks; the line only moves while MDC is low
    task automatic bit_io(input logic en, input logic b, output logic s);
        mdio_en_o = en;
        mdio_d_o = b;
        repeat (4) @(posedge clk_sys_i);
        #1;
        s = mdio_i;
        mdc_o = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        mdc_o = 1'b0;
    endtask

    // Whole frame with its own preamble; a read releases TA and data
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [31:0] hdr;
        logic        s;
        logic        wr;
        wr = (op != 2'h2);
        hdr = {2'h1, op, phy, ra, 2'h2, 16'h0000};
        rd = 16'h0000;
        repeat (32) bit_io(1'b1, 1'b1, s);
        for (int i = 31; i >= 16; i--) begin
            bit_io(wr || (i > 17), hdr[i], s);
        end
        for (int i = 15; i >= 0; i--) begin
            bit_io(wr, wd[i], s);
            rd[i] = s;
        end
        mdio_en_o = 1'b0;
        repeat (12) @(posedge clk_sys_i);
        #1;
    endtask
endmodule

// [tb_top.sv]
// Bench that checks the extended control bank through MDIO frames
`timescale 1ns/100ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        mdc;
    logic        host_d;
    logic        host_en;
    logic        line_lvl;
    logic        dut_d;
    logic        dut_oe_n;
    logic        strap_node = 1'b1;
    logic        strap_spd = 1'b0;
    logic        spd_pin = 1'b0;
    logic        basic_spd = 1'b1;
    logic        rfault = 1'b0;
    logic        link_raw = 1'b0;
    logic        pol_dis;
    logic        sqe_dis;
    logic        sql_dis;
    logic        link_pass;
    logic        spd100;
    logic        rep_mode;
    logic [1:0]  bank;
    logic        xo_auto;
    logic        xo_man;
    logic        tri_st;
    logic        apd;
    logic [15:0] led;
    logic [15:0] rd;
    int          n_fail = 0;
    int          compares = 0;

    // Clock of 4 ns
    always #2 clk = ~clk;
    // Open line with pull-up: released means high
    assign line_lvl = !dut_oe_n ? dut_d : (host_en ? host_d : 1'b1);

    pxc_sta_model u_pxc_sta_model (
        .clk_sys_i(clk), .mdc_o(mdc), .mdio_d_o(host_d),
        .mdio_en_o(host_en), .mdio_i(line_lvl));

    pxc_ext_ctrl u_pxc_ext_ctrl (
        .clk_sys_i(clk), .sys_rst_i(rst), .mdc_i(mdc), .mdio_i(line_lvl),
        .mdio_o(dut_d), .mdio_oe_n_o(dut_oe_n),
        .strap_node_mode_i(strap_node), .strap_speed_src_i(strap_spd),
        .speed_pin_i(spd_pin), .basic_speed_sel_i(basic_spd),
        .remote_fault_i(rfault), .link_pass_raw_i(link_raw),
        .pol_correct_dis_o(pol_dis), .sqe_test_dis_o(sqe_dis),
        .squelch_dis_o(sql_dis), .link_pass_o(link_pass),
        .speed_100_o(spd100), .repeater_mode_o(rep_mode),
        .bank_sel_o(bank), .crossover_auto_enable_o(xo_auto),
        .crossover_manual_select_o(xo_man),
        .line_output_tristate_o(tri_st), .auto_powerdown_en_o(apd),
        .out_led_ctrl_o(led));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        u_pxc_sta_model.frame(pxc_pkg::OP_WR, 5'h01, ra, d, rd);
    endtask

    task automatic rdchk(input logic [4:0] ra, input logic [15:0] exp);
        u_pxc_sta_model.frame(pxc_pkg::OP_RD, 5'h01, ra, 16'h0000, rd);
        chk_word(rd, exp);
    endtask

    task automatic conclude;
        $display("Compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog so a stuck frame cannot hang the run
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        conclude();
    end

    initial begin
        tick(8);
        rst = 1'b0;
        tick(1);
        rdchk(pxc_pkg::OFF_TBT_OPS, 16'h0000);
        rdchk(pxc_pkg::OFF_EXT_A, 16'h8201);
        rdchk(pxc_pkg::OFF_OUT_LED, 16'h3FE9);
        chk_bit(apd, 1'b1);
        chk_bit(tri_st, 1'b0);
        chk_bit(link_pass, 1'b0);
        chk_bit(rep_mode, 1'b1);
        chk_bit(xo_auto, 1'b1);
        chk_bit(xo_man, 1'b0);
        $display("Test reset values done");
        // Each inhibit alone, so a swapped bit shows up
        for (int i = 0; i < 4; i++) begin
            wr(pxc_pkg::OFF_TBT_OPS, 16'h0001 << i);
            rdchk(pxc_pkg::OFF_TBT_OPS, 16'h0001 << i);
            chk_bit(sql_dis, i == 0);
            chk_bit(link_pass, i == 1);
            chk_bit(sqe_dis, i == 2);
            chk_bit(pol_dis, i == 3);
        end
        link_raw = 1'b1;
        tick(3);
        chk_bit(link_pass, 1'b1);
        link_raw = 1'b0;
        tick(3);
        chk_bit(link_pass, 1'b0);
        wr(pxc_pkg::OFF_TBT_OPS, 16'hFFFF);
        rdchk(pxc_pkg::OFF_TBT_OPS, 16'h000F);
        chk_bit(link_pass, 1'b1);
        $display("Test inhibit bits done");
        rfault = 1'b1;
        wr(pxc_pkg::OFF_EXT_A, 16'hFFFF);
        rdchk(pxc_pkg::OFF_EXT_A, 16'hFBFF);
        chk_bit(tri_st, 1'b1);
        chk_bit(rep_mode, 1'b1);
        chk_bit(xo_auto, 1'b1);
        chk_bit(xo_man, 1'b1);
        chk_word({14'h0000, bank}, 16'h0003);
        rdchk(pxc_pkg::OFF_OUT_LED, 16'h3FE9);
        wr(pxc_pkg::OFF_EXT_A, 16'h0800);
        chk_bit(apd, 1'b0);
        chk_bit(tri_st, 1'b0);
        chk_bit(rep_mode, 1'b0);
        chk_bit(xo_auto, 1'b0);
        chk_bit(xo_man, 1'b0);
        rdchk(pxc_pkg::OFF_OUT_LED, 16'h0000);
        wr(pxc_pkg::OFF_OUT_LED, 16'h1234);
        wr(pxc_pkg::OFF_EXT_A, 16'h1001);
        rdchk(pxc_pkg::OFF_EXT_A, 16'h3001);
        rdchk(pxc_pkg::OFF_OUT_LED, 16'h3FE9);
        wr(pxc_pkg::OFF_OUT_LED, 16'h1234);
        rdchk(pxc_pkg::OFF_OUT_LED, 16'h1234);
        chk_word(led, 16'h1234);
        $display("Test control register done");
        chk_bit(spd100, 1'b1);
        basic_spd = 1'b0;
        tick(3);
        chk_bit(spd100, 1'b0);
        wr(pxc_pkg::OFF_EXT_A, 16'h4001);
        spd_pin = 1'b1;
        tick(4);
        chk_bit(spd100, 1'b1);
        basic_spd = 1'b1;
        spd_pin = 1'b0;
        tick(4);
        chk_bit(spd100, 1'b0);
        $display("Test speed source done");
        // Frames the bank must drop
        u_pxc_sta_model.frame(pxc_pkg::OP_WR, 5'h02, 5'h12, 16'h0000, rd);
        u_pxc_sta_model.frame(2'h3, 5'h01, 5'h12, 16'h0000, rd);
        rdchk(pxc_pkg::OFF_TBT_OPS, 16'h000F);
        rdchk(5'h1F, 16'h0000);
        $display("Test refused frames done");
        conclude();
    end
endmodule
